// *** rtl/dmba_pkg.sv ***
/*
  constants for the banked data memory address generator: register offsets,
  reset values, address map points, widths and ahb bus settings.
  assumes a 32-bit ahb-lite register bus and a 12-bit byte-wide data ram.
*/
package dmba_pkg;
  localparam int unsigned RAM_AW     = 12;
  localparam int unsigned BANK_W     = 4;
  localparam int unsigned OFS_W      = 8;
  localparam int unsigned NUM_PTR    = 3;

  localparam logic [7:0] REG_BANK_SEL = 8'h00;
  localparam logic [7:0] REG_PTR0     = 8'h04;
  localparam logic [7:0] REG_PTR1     = 8'h08;
  localparam logic [7:0] REG_PTR2     = 8'h0c;
  localparam logic [7:0] REG_LAST     = 8'h10;

  localparam logic [3:0]  BANK_SEL_RST = 4'h0;
  localparam logic [3:0]  PTR_HI_RST   = 4'h0;
  localparam logic [7:0]  PTR_LO_RST   = 8'h00;
  localparam logic [11:0] LAST_RST     = 12'h000;

  localparam logic [3:0]  LOW_BANK     = 4'h0;
  localparam logic [3:0]  SFR_BANK     = 4'hf;
  localparam logic [7:0]  ACCESS_MID   = 8'h80;
  localparam logic [4:0]  IMPL_BANKS   = 5'h06;
  localparam logic [11:0] IND_PORT_BASE = 12'hff0;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [31:0] HRDATA_RST    = 32'h0000_0000;

  typedef enum logic [0:0] {
    DMBA_BUS_IDLE = 1'b0,
    DMBA_BUS_DATA = 1'b1
  } dmba_bus_t;
endpackage

// *** rtl/dmba_ptr.sv ***
/*
  one indirect pointer: a high nibble and a low byte together forming a 12-bit
  ram address, loadable from the bus and stepped after indirect accesses.
  assumes load, increment and decrement come from logic on the same clock.
*/
`timescale 1ns/1ps
module dmba_ptr
  import dmba_pkg::*;
(
  input  wire logic                         clk_in,
  input  wire logic                         rstn_in,
  input  wire logic                         load_in,
  input  wire logic [dmba_pkg::RAM_AW-1:0]  load_val_in,
  input  wire logic                         inc_in,
  input  wire logic                         dec_in,
  output logic      [dmba_pkg::RAM_AW-1:0]  ptr_out
);
  logic [3:0] hi;
  logic [7:0] lo;
  logic [3:0] next_hi;
  logic [7:0] next_lo;
  logic [11:0] stepped;

  always_comb begin
    stepped = {hi, lo};
    if (inc_in) begin
      stepped = {hi, lo} + 12'h001;
    end else if (dec_in) begin
      stepped = {hi, lo} - 12'h001;
    end
    next_hi = stepped[11:8];
    next_lo = stepped[7:0];
    if (load_in) begin
      next_hi = load_val_in[11:8];
      next_lo = load_val_in[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hi <= PTR_HI_RST;
      lo <= PTR_LO_RST;
    end else begin
      hi <= next_hi;
      lo <= next_lo;
    end
  end

  assign ptr_out = {hi, lo};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_ptr_inc;
    (inc_in && !load_in) |=> (ptr_out == $past(ptr_out) + 12'h001);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer increment wrong");

  property p_ptr_dec_wrap;
    (dec_in && !inc_in && !load_in && ptr_out == 12'h100) |=> (ptr_out == 12'h0ff);
  endproperty
  a_ptr_dec_wrap: assert property (p_ptr_dec_wrap) else $error("borrow not into high");
endmodule

// *** rtl/dmba_top.sv ***
/*
  banked data memory address generator with ahb-lite register access.
  assumes the cpu path gives one access request a cycle with its operands,
  and the data ram returns read data combinationally in the same cycle as its address.
*/
// Chosen here: register access over AHB-Lite and the placing of the registers.
// Behaviour
// - access window is low 128 bytes of bank 0 plus top 128 of bank 15.
// - access bit zero selects the access window, one selects the bank register.
// - forced window maps the 8-bit offset contiguously from low half into high half.
// - special function registers sit in the window high half, no banking needed.
// - sixteen banks; bank register low nibble gives the address top four bits.
// - bank register upper four bits read zero and ignore writes.
// - unimplemented bank reads zero and drops writes.
// - each bank holds 256 bytes addressed by an 8-bit offset.
// - full-address move ignores the bank register and uses its own 12 bits.
// - a literal load instruction sets the bank register.
// - naming an indirect port accesses the location held in its pointer.
// - each pointer holds a full 12-bit address across all ram.
// - indirect port has no storage; it redirects through its pointer.
// - indirect read whose pointer names an indirect port returns zero.
// - indirect write whose pointer names an indirect port does nothing.
// - three independent pointers, each a high and low register.
// - pointer steps carry across all 12 bits and touch no flags.
`timescale 1ns/1ps
module dmba_top
  import dmba_pkg::*;
(
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  input  wire logic                          hsel_in,
  input  wire logic [31:0]                   haddr_in,
  input  wire logic [1:0]                    htrans_in,
  input  wire logic                          hwrite_in,
  input  wire logic [2:0]                    hsize_in,
  input  wire logic [31:0]                   hwdata_in,
  input  wire logic                          hready_in,
  output logic      [31:0]                   hrdata_out,
  output logic                               hreadyout_out,
  output logic                               hresp_out,
  input  wire logic                          cpu_req_in,
  input  wire logic                          cpu_we_in,
  input  wire logic                          cpu_access_in,
  input  wire logic [dmba_pkg::OFS_W-1:0]    cpu_faddr_in,
  input  wire logic                          cpu_full_in,
  input  wire logic [dmba_pkg::RAM_AW-1:0]   cpu_full_addr_in,
  input  wire logic [7:0]                    cpu_wdata_in,
  input  wire logic                          cpu_load_bank_in,
  input  wire logic [7:0]                    cpu_bank_lit_in,
  input  wire logic [dmba_pkg::NUM_PTR-1:0]  cpu_ptr_inc_in,
  input  wire logic [dmba_pkg::NUM_PTR-1:0]  cpu_ptr_dec_in,
  output logic      [7:0]                    cpu_rdata_out,
  output logic                               cpu_rvalid_out,
  output logic      [dmba_pkg::RAM_AW-1:0]   ram_addr_out,
  output logic                               ram_we_out,
  output logic                               ram_re_out,
  output logic      [7:0]                    ram_wdata_out,
  input  wire logic [7:0]                    ram_rdata_in
);
  import dmba_pkg::*;

  function automatic logic [2:0] ind_port_hit(input logic [11:0] a);
    logic [2:0] hit;
    hit = 3'b000;
    for (int i = 0; i < NUM_PTR; i++) begin
      if (a == IND_PORT_BASE + 12'(i)) begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic bank_present(input logic [3:0] b);
    return ({1'b0, b} < IMPL_BANKS) || (b == SFR_BANK);
  endfunction

  dmba_bus_t   state;
  dmba_bus_t   next_state;
  logic [7:0]  bus_addr;
  logic [7:0]  next_bus_addr;
  logic        bus_wr;
  logic        next_bus_wr;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic [3:0]  ram_bank_select;
  logic [3:0]  next_bank;
  logic [11:0] last_addr;
  logic [11:0] next_last_addr;
  logic [2:0]  ptr_load;
  logic [11:0] ptr_val [NUM_PTR];

  logic [11:0] direct_addr;
  logic [2:0]  hit;
  logic [11:0] ptr_sel;
  logic [11:0] eff_addr;
  logic        ptr_null;
  logic        unimpl;
  logic        blocked;
  logic [11:0] next_ram_addr;
  logic        next_ram_we;
  logic        next_ram_re;
  logic [7:0]  next_ram_wdata;
  logic        rd_pend;
  logic        next_rd_pend;
  logic        rd_zero;
  logic        next_rd_zero;
  logic [7:0]  next_cpu_rdata;
  logic        next_cpu_rvalid;

  // ahb-lite slave: one wait state on every NONSEQ transfer
  always_comb begin
    next_state     = state;
    next_bus_addr  = bus_addr;
    next_bus_wr    = bus_wr;
    next_hrdata    = hrdata_out;
    next_hreadyout = hreadyout_out;
    ptr_load       = 3'b000;
    case (state)
      DMBA_BUS_IDLE: begin
        if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ) begin
          next_state     = DMBA_BUS_DATA;
          next_bus_addr  = haddr_in[7:0];
          next_bus_wr    = hwrite_in;
          next_hreadyout = 1'b0;
        end
      end
      DMBA_BUS_DATA: begin
        next_state     = DMBA_BUS_IDLE;
        next_hreadyout = 1'b1;
        next_hrdata    = HRDATA_RST;
        if (bus_addr == REG_BANK_SEL) begin
          next_hrdata = {28'h000_0000, ram_bank_select};
        end else if (bus_addr == REG_PTR0) begin
          next_hrdata = {20'h0_0000, ptr_val[0]};
          ptr_load[0] = bus_wr;
        end else if (bus_addr == REG_PTR1) begin
          next_hrdata = {20'h0_0000, ptr_val[1]};
          ptr_load[1] = bus_wr;
        end else if (bus_addr == REG_PTR2) begin
          next_hrdata = {20'h0_0000, ptr_val[2]};
          ptr_load[2] = bus_wr;
        end else if (bus_addr == REG_LAST) begin
          next_hrdata = {20'h0_0000, last_addr};
        end
        if (bus_wr) begin
          next_hrdata = HRDATA_RST;
        end
      end
      default: begin
        next_state = DMBA_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state         <= DMBA_BUS_IDLE;
      bus_addr      <= 8'h00;
      bus_wr        <= 1'b0;
      hrdata_out    <= HRDATA_RST;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      state         <= next_state;
      bus_addr      <= next_bus_addr;
      bus_wr        <= next_bus_wr;
      hrdata_out    <= next_hrdata;
      hreadyout_out <= next_hreadyout;
      hresp_out     <= 1'b0;
    end
  end

  // bank select: literal load from the cpu wins over a bus write
  always_comb begin
    next_bank = ram_bank_select;
    if (state == DMBA_BUS_DATA && bus_wr && bus_addr == REG_BANK_SEL) begin
      next_bank = hwdata_in[3:0];
    end
    if (cpu_load_bank_in) begin
      next_bank = cpu_bank_lit_in[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ram_bank_select <= BANK_SEL_RST;
    end else begin
      ram_bank_select <= next_bank;
    end
  end

  generate
    for (genvar g = 0; g < NUM_PTR; g++) begin : g_ptr
      dmba_ptr u_ptr (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .load_in     (ptr_load[g]),
        .load_val_in (hwdata_in[11:0]),
        .inc_in      (cpu_ptr_inc_in[g]),
        .dec_in      (cpu_ptr_dec_in[g]),
        .ptr_out     (ptr_val[g])
      );
    end
  endgenerate

  // address formation
  always_comb begin
    if (cpu_full_in) begin
      direct_addr = cpu_full_addr_in;
    end else if (!cpu_access_in) begin
      if (cpu_faddr_in < ACCESS_MID) begin
        direct_addr = {LOW_BANK, cpu_faddr_in};
      end else begin
        direct_addr = {SFR_BANK, cpu_faddr_in};
      end
    end else begin
      direct_addr = {ram_bank_select, cpu_faddr_in};
    end
    hit     = ind_port_hit(direct_addr);
    ptr_sel = 12'h000;
    for (int i = 0; i < NUM_PTR; i++) begin
      if (hit[i]) begin
        ptr_sel = ptr_val[i];
      end
    end
    eff_addr = (hit != 3'b000) ? ptr_sel : direct_addr;
    ptr_null = (hit != 3'b000) && (ind_port_hit(ptr_sel) != 3'b000);
    unimpl   = !bank_present(eff_addr[11:8]);
    blocked  = ptr_null || unimpl;
  end

  // ram request stage and read return stage
  always_comb begin
    next_ram_addr   = ram_addr_out;
    next_ram_wdata  = ram_wdata_out;
    next_ram_we     = 1'b0;
    next_ram_re     = 1'b0;
    next_rd_pend    = 1'b0;
    next_rd_zero    = 1'b0;
    next_last_addr  = last_addr;
    if (cpu_req_in) begin
      next_ram_addr  = eff_addr;
      next_last_addr = eff_addr;
      next_ram_wdata = cpu_wdata_in;
      next_ram_we    = cpu_we_in && !blocked;
      next_ram_re    = !cpu_we_in && !blocked;
      next_rd_pend   = !cpu_we_in;
      next_rd_zero   = blocked;
    end
    next_cpu_rvalid = rd_pend;
    next_cpu_rdata  = cpu_rdata_out;
    if (rd_pend) begin
      next_cpu_rdata = rd_zero ? ZERO_BYTE : ram_rdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ram_addr_out   <= LAST_RST;
      ram_we_out     <= 1'b0;
      ram_re_out     <= 1'b0;
      ram_wdata_out  <= ZERO_BYTE;
      rd_pend        <= 1'b0;
      rd_zero        <= 1'b0;
      last_addr      <= LAST_RST;
      cpu_rdata_out  <= ZERO_BYTE;
      cpu_rvalid_out <= 1'b0;
    end else begin
      ram_addr_out   <= next_ram_addr;
      ram_we_out     <= next_ram_we;
      ram_re_out     <= next_ram_re;
      ram_wdata_out  <= next_ram_wdata;
      rd_pend        <= next_rd_pend;
      rd_zero        <= next_rd_zero;
      last_addr      <= next_last_addr;
      cpu_rdata_out  <= next_cpu_rdata;
      cpu_rvalid_out <= next_cpu_rvalid;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_bank_upper_zero;
    (state == DMBA_BUS_DATA && !bus_wr && bus_addr == REG_BANK_SEL)
      |=> (hrdata_out[31:4] == 28'h000_0000 && hreadyout_out);
  endproperty
  a_bank_upper_zero: assert property (p_bank_upper_zero) else $error("bank upper bits set");

  property p_access_low;
    (cpu_req_in && !cpu_full_in && !cpu_access_in && cpu_faddr_in < ACCESS_MID)
      |=> (ram_addr_out == {LOW_BANK, $past(cpu_faddr_in)});
  endproperty
  a_access_low: assert property (p_access_low) else $error("window low half wrong");

  property p_access_high;
    (cpu_req_in && !cpu_full_in && !cpu_access_in && cpu_faddr_in >= ACCESS_MID
      && hit == 3'b000) |=> (ram_addr_out[11:8] == SFR_BANK);
  endproperty
  a_access_high: assert property (p_access_high) else $error("window high half wrong");

  property p_banked;
    (cpu_req_in && !cpu_full_in && cpu_access_in && hit == 3'b000)
      |=> (ram_addr_out == {$past(ram_bank_select), $past(cpu_faddr_in)});
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_full_move;
    (cpu_req_in && cpu_full_in && hit == 3'b000)
      |=> (ram_addr_out == $past(cpu_full_addr_in));
  endproperty
  a_full_move: assert property (p_full_move) else $error("full move address wrong");

  property p_indirect;
    (cpu_req_in && hit != 3'b000 && !ptr_null) |=> (ram_addr_out == $past(ptr_sel));
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");

  property p_null_read;
    (cpu_req_in && !cpu_we_in && ptr_null)
      |-> ##1 !ram_re_out ##1 (cpu_rvalid_out && cpu_rdata_out == ZERO_BYTE);
  endproperty
  a_null_read: assert property (p_null_read) else $error("null read not zero");

  property p_blocked_write;
    (cpu_req_in && cpu_we_in && blocked) |=> !ram_we_out;
  endproperty
  a_blocked_write: assert property (p_blocked_write) else $error("blocked write issued");

  property p_unimpl_read;
    (cpu_req_in && !cpu_we_in && unimpl) |-> ##2 (cpu_rdata_out == ZERO_BYTE);
  endproperty
  a_unimpl_read: assert property (p_unimpl_read) else $error("unimplemented read not zero");

  property p_load_bank;
    cpu_load_bank_in |=> (ram_bank_select == $past(cpu_bank_lit_in[3:0]));
  endproperty
  a_load_bank: assert property (p_load_bank) else $error("bank literal not loaded");

  c_indirect_read: cover property (cpu_req_in && !cpu_we_in && hit != 3'b000 && !ptr_null);
  c_window_high: cover property (cpu_req_in && !cpu_access_in && cpu_faddr_in >= ACCESS_MID);
  c_unimpl_write: cover property (cpu_req_in && cpu_we_in && unimpl);
  c_bus_write: cover property (state == DMBA_BUS_DATA && bus_wr);
endmodule

// *** verif/dmba_ram_model.sv ***
/*
  data ram model facing the address generator: 4096 bytes, combinational read,
  write on the rising edge. assumes the design's clock and registered ram outputs.
*/
`timescale 1ns/1ps
module dmba_ram_model (
  input  wire logic        clk_in,
  input  wire logic [11:0] addr_in,
  input  wire logic        we_in,
  input  wire logic        re_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:4095];

  // known fill pattern so unwritten reads stay definite
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'h5a ^ i[7:0];
    end
  end

  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // idle line shows the inverted byte so stale data never passes
  assign rdata_out = re_in ? mem[addr_in] : ~mem[addr_in];
endmodule

// *** verif/tb_dmba_top.sv ***
/*
  self-checking bench for the banked data memory address generator.
  assumes ahb-lite registers at the package offsets and a combinational ram.
*/
`timescale 1ns/1ps
module tb_dmba_top;
  import dmba_pkg::*;
  logic        clk_in      = 1'b0;
  logic        rstn_in     = 1'b0;
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0000_0000;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [2:0]  hsize       = 3'h0;
  logic [31:0] hwdata      = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        cpu_req     = 1'b0;
  logic        cpu_we      = 1'b0;
  logic        cpu_acc     = 1'b0;
  logic [7:0]  cpu_fa      = 8'h00;
  logic        cpu_full    = 1'b0;
  logic [11:0] cpu_fulla   = 12'h000;
  logic [7:0]  cpu_wd      = 8'h00;
  logic        cpu_ldb     = 1'b0;
  logic [7:0]  cpu_lit     = 8'h00;
  logic [2:0]  cpu_inc     = 3'h0;
  logic [2:0]  cpu_dec     = 3'h0;
  logic [7:0]  cpu_rdata;
  logic        cpu_rvalid;
  logic [11:0] ram_addr;
  logic        ram_we;
  logic        ram_re;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;
  int          checks      = 0;
  int          n_mismatch  = 0;
  int          cycles      = 0;

  dmba_top i_dmba_top (
    .clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .cpu_req_in(cpu_req), .cpu_we_in(cpu_we),
    .cpu_access_in(cpu_acc), .cpu_faddr_in(cpu_fa), .cpu_full_in(cpu_full),
    .cpu_full_addr_in(cpu_fulla), .cpu_wdata_in(cpu_wd), .cpu_load_bank_in(cpu_ldb),
    .cpu_bank_lit_in(cpu_lit), .cpu_ptr_inc_in(cpu_inc), .cpu_ptr_dec_in(cpu_dec),
    .cpu_rdata_out(cpu_rdata), .cpu_rvalid_out(cpu_rvalid), .ram_addr_out(ram_addr),
    .ram_we_out(ram_we), .ram_re_out(ram_re), .ram_wdata_out(ram_wdata),
    .ram_rdata_in(ram_rdata)
  );

  dmba_ram_model i_dmba_ram_model (
    .clk_in(clk_in), .addr_in(ram_addr), .we_in(ram_we), .re_in(ram_re),
    .wdata_in(ram_wdata), .rdata_out(ram_rdata)
  );

  always #5 clk_in = ~clk_in;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single ahb transfer: address phase, then data phase until hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0);
    hsel <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp);
  endtask

  // one cpu data access; ram outputs one edge after taking, read data one later
  task automatic cpu_op(input logic we, input logic acc, input logic [7:0] fa,
                        input logic [7:0] wd, input logic ok, input logic [11:0] ea,
                        input logic [7:0] erd, input logic full = 1'b0,
                        input logic [11:0] fulla = 12'h000);
    @(posedge clk_in);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_acc <= acc;
    cpu_fa <= fa;
    cpu_wd <= wd;
    cpu_full <= full;
    cpu_fulla <= fulla;
    @(posedge clk_in);
    cpu_req <= 1'b0;
    #1;
    check(cpu_rvalid, 1'b0);
    if (ok) begin
      check(ram_addr, ea);
      check({ram_we, ram_re}, {we, !we});
      if (we) begin
        check(ram_wdata, wd);
      end
    end else begin
      check({ram_we, ram_re}, 2'h0);
    end
    if (!we) begin
      @(posedge clk_in);
      #1;
      check({cpu_rvalid, cpu_rdata}, {1'b1, erd});
    end
  endtask

  task automatic load_bank(input logic [7:0] lit);
    @(posedge clk_in);
    cpu_ldb <= 1'b1;
    cpu_lit <= lit;
    @(posedge clk_in);
    cpu_ldb <= 1'b0;
  endtask

  task automatic t_reset();
    rd_chk(REG_BANK_SEL, 32'h0000_0000);
    rd_chk(REG_PTR0, 32'h0000_0000);
    rd_chk(REG_PTR1, 32'h0000_0000);
    rd_chk(REG_PTR2, 32'h0000_0000);
    rd_chk(REG_LAST, 32'h0000_0000);
    rd_chk(8'h14, 32'h0000_0000);
  endtask

  task automatic t_bank();
    wr_reg(REG_BANK_SEL, 32'h0000_00ff);
    rd_chk(REG_BANK_SEL, 32'h0000_000f);
    load_bank(8'ha3);
    rd_chk(REG_BANK_SEL, 32'h0000_0003);
  endtask

  task automatic t_direct();
    cpu_op(1'b1, 1'b1, 8'h45, 8'hc3, 1'b1, 12'h345, 8'h00);
    cpu_op(1'b0, 1'b1, 8'h45, 8'h00, 1'b1, 12'h345, 8'hc3);
    cpu_op(1'b1, 1'b1, 8'hff, 8'h3c, 1'b1, 12'h3ff, 8'h00);
    cpu_op(1'b0, 1'b1, 8'h00, 8'h00, 1'b1, 12'h300, 8'h5a);
  endtask

  task automatic t_window();
    logic [7:0] ofs [4];
    ofs = '{8'h00, 8'h7f, 8'hff, 8'h80};
    for (int i = 0; i < 4; i++) begin
      cpu_op(1'b1, 1'b0, ofs[i], 8'h11, 1'b1, {ofs[i][7] ? SFR_BANK : LOW_BANK, ofs[i]},
             8'h00);
    end
    cpu_op(1'b0, 1'b0, 8'h45, 8'h00, 1'b1, 12'h045, 8'h1f);
    cpu_op(1'b0, 1'b0, 8'hc0, 8'h00, 1'b1, 12'hfc0, 8'h9a);
    rd_chk(REG_LAST, 32'h0000_0fc0);
  endtask

  task automatic t_unimpl();
    load_bank(8'h06);
    cpu_op(1'b0, 1'b1, 8'h10, 8'h00, 1'b0, 12'h000, 8'h00);
    cpu_op(1'b1, 1'b1, 8'h10, 8'h77, 1'b0, 12'h000, 8'h00);
    cpu_op(1'b1, 1'b0, 8'hab, 8'hcd, 1'b1, 12'h2bc, 8'h00, 1'b1, 12'h2bc);
    cpu_op(1'b0, 1'b1, 8'h00, 8'h00, 1'b1, 12'h2bc, 8'hcd, 1'b1, 12'h2bc);
    load_bank(8'h05);
    cpu_op(1'b0, 1'b1, 8'h10, 8'h00, 1'b1, 12'h510, 8'h4a);
  endtask

  task automatic t_indirect();
    wr_reg(REG_PTR1, 32'h0000_02a5);
    rd_chk(REG_PTR1, 32'h0000_02a5);
    cpu_op(1'b1, 1'b0, 8'hf1, 8'h77, 1'b1, 12'h2a5, 8'h00);
    load_bank(8'h02);
    cpu_op(1'b0, 1'b1, 8'ha5, 8'h00, 1'b1, 12'h2a5, 8'h77);
    load_bank(8'h0f);
    cpu_op(1'b0, 1'b1, 8'hf1, 8'h00, 1'b1, 12'h2a5, 8'h77);
    wr_reg(REG_PTR0, {20'h0_0000, IND_PORT_BASE + 12'h002});
    cpu_op(1'b0, 1'b0, 8'hf0, 8'h00, 1'b0, 12'h000, ZERO_BYTE);
    cpu_op(1'b1, 1'b0, 8'hf0, 8'h55, 1'b0, 12'h000, 8'h00);
  endtask

  task automatic t_step();
    wr_reg(REG_PTR2, 32'h0000_00ff);
    @(posedge clk_in);
    cpu_inc <= 3'h4;
    @(posedge clk_in);
    cpu_inc <= 3'h0;
    rd_chk(REG_PTR2, 32'h0000_0100);
    rd_chk(REG_PTR1, 32'h0000_02a5);
    @(posedge clk_in);
    cpu_dec <= 3'h4;
    @(posedge clk_in);
    cpu_dec <= 3'h0;
    rd_chk(REG_PTR2, 32'h0000_00ff);
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_bank();
    t_direct();
    t_window();
    t_unimpl();
    t_indirect();
    t_step();
    close_out();
  end
endmodule
